// [rtl/eed_pkg.sv]
// Constants for the execution exception detect block.
// Assumes a single core clock domain and synchronous active-low reset.
package eed_pkg;
  localparam int unsigned EED_XLEN = 32;
  localparam logic [4:0] EED_CODE_OV = 5'h0C;
  localparam logic [4:0] EED_CODE_RI = 5'h0A;
  localparam logic [4:0] EED_CODE_CPU = 5'h0B;
  localparam logic [4:0] EED_CODE_SIGPROC_DISABLED_CODE = 5'h1A;
  localparam logic [4:0] EED_CODE_C2E = 5'h12;
  localparam logic [4:0] EED_CODE_IS1 = 5'h10;
  localparam logic [31:0] EED_GEN_OFFSET = 32'h00000180;
  localparam logic [31:0] EED_EBASE_RESET = 32'h80000000;
  localparam logic [31:0] EED_DEBUG_VECTOR = 32'hBFC00480;
  localparam logic [1:0] EED_UNIT_CP0 = 2'h0;
  localparam logic [1:0] EED_UNIT_CP1 = 2'h1;
  localparam logic [1:0] EED_UNIT_CP2 = 2'h2;
  // System-control register numbers and selects
  localparam logic [4:0] EED_REG_USER_HWREG_ENABLE = 5'h07;
  localparam logic [4:0] EED_REG_CAUSE = 5'h0D;
  localparam logic [4:0] EED_REG_EPC = 5'h0E;
  localparam logic [4:0] EED_REG_DEBUG = 5'h17;
  localparam logic [4:0] EED_REG_DEBUG_RETURN_PC = 5'h18;
  localparam logic [4:0] EED_REG_SRAMERR = 5'h1B;
  localparam logic [2:0] EED_SEL_0 = 3'h0;
  localparam logic [2:0] EED_SEL_COMPLEX_BREAK_INFO = 3'h6;
  // Field positions
  localparam int unsigned EED_CAUSE_CODE_LSB = 2;
  localparam int unsigned EED_CAUSE_CE_LSB = 28;
  localparam int unsigned EED_CAUSE_BD_BIT = 31;
  localparam logic [31:0] EED_USER_HWREG_ENABLE_MASK = 32'h2000000F;
  localparam int unsigned EED_DBG_DBD_BIT = 31;
  localparam int unsigned EED_DBG_LOAD_BREAK_FLAG_BIT = 2;
  localparam int unsigned EED_DBG_STORE_BREAK_FLAG_BIT = 3;
  localparam int unsigned EED_DBG_IMPRECISE_INSTR_BREAK_FLAG_BIT = 19;
  localparam int unsigned EED_DBG_IMPRECISE_LOAD_BREAK_FLAG_BIT = 18;
  localparam int unsigned EED_DBG_IMPRECISE_STORE_BREAK_FLAG_BIT = 17;
  localparam int unsigned EED_CBRK_W = 4;
  typedef enum logic [2:0] {
    EED_ST_RUN = 3'b001,
    EED_ST_GEN = 3'b010,
    EED_ST_DBG = 3'b100
  } eed_state_t;
endpackage : eed_pkg

// [rtl/eed_core.sv]
// Execution-class exception detection, cause coding, saved state and vectors.
// Assumes decode/execute present one qualified instruction per cycle with ex_valid_i.
// Behaviour
// - Undefined opcode or function raises reserved instruction
// - Compressed mode: undefined or unconfigured gives reserved
// - Full mode: coprocessor/DSP groups give unusable instead
// - One priority level; reserved order follows mode
// - Coprocessor with clear usable bit is unusable
// - System coprocessor op in user mode unusable
// - Unusable writes unit number into cause
// - DSP op with enable clear gives disabled
// - Coprocessor 2 general exception takes its code
// - Coprocessor 2 specific condition takes specific code
// - Selected arithmetic overflow raises overflow
// - These exceptions enter general vector at offset; the code drops them while exception_level_bit_i is set
// - Data break enters debug, sets load/store flag
// - Data-broken load/store does not complete
// - Complex break imprecise, points at later instruction
// - Complex break sets imprecise flags and info
// - General path excludes reset, NMI, debug, ECC
// - Interrupts masked by enable, masks, exception level
// - Registers addressed by number and select
// - Register 7 holds user hardware-read enables
// - Register 27 select 0 records SRAM errors
//
// Our own choices: strobed register access and the address map.
module eed_core (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ex_valid_i,
  input wire logic [31:0] ex_pc_i,
  input wire logic ex_in_delay_slot_i,
  input wire logic ex_compressed_mode_i,
  input wire logic ex_undefined_i,
  input wire logic ex_unconfigured_i,
  input wire logic ex_cop_group_i,
  input wire logic ex_dsp_group_i,
  input wire logic [1:0] ex_cop_unit_i,
  input wire logic ex_is_cop_i,
  input wire logic ex_is_dsp_i,
  input wire logic ex_arith_trap_i,
  input wire logic ex_arith_overflow_i,
  input wire logic ex_is_load_i,
  input wire logic ex_is_store_i,
  input wire logic data_break_i,
  input wire logic complex_break_i,
  input wire logic [eed_pkg::EED_CBRK_W-1:0] complex_break_types_i,
  input wire logic complex_instr_i,
  input wire logic complex_load_i,
  input wire logic complex_store_i,
  input wire logic [31:0] later_pc_i,
  input wire logic later_in_delay_slot_i,
  input wire logic cop2_reserved_i,
  input wire logic cop2_error_i,
  input wire logic cop2_impl_i,
  input wire logic [2:0] coproc_usable_bits_i,
  input wire logic sigproc_enable_bit_i,
  input wire logic user_mode_i,
  input wire logic exception_level_bit_i,
  input wire logic global_irq_enable_i,
  input wire logic [7:0] irq_mask_bits_i,
  input wire logic [7:0] irq_pending_i,
  input wire logic sram_err_valid_i,
  input wire logic [31:0] sram_err_info_i,
  input wire logic [4:0] reg_num_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic exc_taken_o,
  output logic debug_taken_o,
  output logic [31:0] vector_o,
  output logic kill_writeback_o,
  output logic irq_o,
  output logic [31:0] user_hwreg_enable_o
);
  import eed_pkg::*;

  logic [4:0] code_q, code_d;
  logic [1:0] ce_q, ce_d;
  logic bd_q;
  logic [31:0] epc_q, debug_return_pc_q, user_hwreg_enable_q, sram_err_q, rdata_q, vector_q;
  logic dbd_q, load_break_flag_q, store_break_flag_q, dibi_q, ddbli_q, ddbsi_q;
  logic [EED_CBRK_W-1:0] cbrk_q;
  eed_state_t state_q, state_d;

  // Cause decode; several of these can fire from the same instruction
  wire cop_unusable_bit = ex_is_cop_i && (ex_cop_unit_i != EED_UNIT_CP0)
    && !coproc_usable_bits_i[ex_cop_unit_i];
  wire cp0_user = ex_is_cop_i && (ex_cop_unit_i == EED_UNIT_CP0) && user_mode_i;
  wire full_undef = !ex_compressed_mode_i && ex_undefined_i;
  wire full_undef_cpu = full_undef && (ex_cop_group_i || ex_dsp_group_i);
  wire full_undef_ri = full_undef && !(ex_cop_group_i || ex_dsp_group_i);
  wire comp_ri = ex_compressed_mode_i && (ex_undefined_i || ex_unconfigured_i);
  wire ri = full_undef_ri || comp_ri || (ex_is_cop_i && ex_cop_unit_i == EED_UNIT_CP2
    && cop2_reserved_i);
  wire cpu = cop_unusable_bit || cp0_user || full_undef_cpu;
  wire sigproc_disabled_code = ex_is_dsp_i && !sigproc_enable_bit_i && !ex_undefined_i;
  wire cop2_ok = ex_is_cop_i && ex_cop_unit_i == EED_UNIT_CP2 && !cop2_reserved_i && !cpu;
  wire c2e = cop2_ok && cop2_error_i;
  wire is1 = cop2_ok && cop2_impl_i && !cop2_error_i;
  wire ov = ex_arith_trap_i && ex_arith_overflow_i;
  wire any_gen = ex_valid_i && (ri || cpu || sigproc_disabled_code || c2e || is1 || ov);
  wire dbrk = ex_valid_i && data_break_i && (ex_is_load_i || ex_is_store_i);

  // Shared level; compressed mode lets reserved win first, full mode lets unusable win
  always_comb begin
    code_d = code_q;
    ce_d = ce_q;
    if (ex_compressed_mode_i && ri) begin
      code_d = EED_CODE_RI;
    end else if (cpu) begin
      code_d = EED_CODE_CPU;
      ce_d = full_undef_cpu && ex_dsp_group_i ? EED_UNIT_CP0 : ex_cop_unit_i;
    end else if (ri) begin
      code_d = EED_CODE_RI;
    end else if (sigproc_disabled_code) begin
      code_d = EED_CODE_SIGPROC_DISABLED_CODE;
    end else if (c2e) begin
      code_d = EED_CODE_C2E;
    end else if (is1) begin
      code_d = EED_CODE_IS1;
    end else if (ov) begin
      code_d = EED_CODE_OV;
    end
  end

  // Debug exceptions outrank the general path, which never sees them
  always_comb begin
    state_d = EED_ST_RUN;
    if (dbrk || complex_break_i) begin
      state_d = EED_ST_DBG;
    end else if (any_gen && !exception_level_bit_i) begin
      state_d = EED_ST_GEN;
    end
  end

  wire take_gen = state_d == EED_ST_GEN;
  wire take_dbg = state_d == EED_ST_DBG;
  wire [31:0] gen_vector = EED_EBASE_RESET + EED_GEN_OFFSET;
  wire [31:0] next_vector = take_dbg ? EED_DEBUG_VECTOR : gen_vector;
  wire [31:0] restart_pc = ex_in_delay_slot_i ? ex_pc_i - 32'h00000004 : ex_pc_i;
  wire [31:0] dbg_pc = dbrk ? restart_pc : later_pc_i;
  wire dbg_bd = dbrk ? ex_in_delay_slot_i : later_in_delay_slot_i;

  // Register addressing by number and select
  wire sel_user_hwreg_enable = reg_num_i == EED_REG_USER_HWREG_ENABLE && reg_sel_i == EED_SEL_0;
  wire sel_cause = reg_num_i == EED_REG_CAUSE && reg_sel_i == EED_SEL_0;
  wire sel_epc = reg_num_i == EED_REG_EPC && reg_sel_i == EED_SEL_0;
  wire sel_debug = reg_num_i == EED_REG_DEBUG && reg_sel_i == EED_SEL_0;
  wire sel_complex_break_info = reg_num_i == EED_REG_DEBUG && reg_sel_i == EED_SEL_COMPLEX_BREAK_INFO;
  wire sel_debug_return_pc = reg_num_i == EED_REG_DEBUG_RETURN_PC && reg_sel_i == EED_SEL_0;
  wire sel_sram = reg_num_i == EED_REG_SRAMERR && reg_sel_i == EED_SEL_0;
  wire [31:0] cause_word = ({31'h0, bd_q} << EED_CAUSE_BD_BIT)
    | ({30'h0, ce_q} << EED_CAUSE_CE_LSB) | ({27'h0, code_q} << EED_CAUSE_CODE_LSB);
  wire [31:0] debug_word = ({31'h0, dbd_q} << EED_DBG_DBD_BIT)
    | ({31'h0, load_break_flag_q} << EED_DBG_LOAD_BREAK_FLAG_BIT) | ({31'h0, store_break_flag_q} << EED_DBG_STORE_BREAK_FLAG_BIT)
    | ({31'h0, dibi_q} << EED_DBG_IMPRECISE_INSTR_BREAK_FLAG_BIT) | ({31'h0, ddbli_q} << EED_DBG_IMPRECISE_LOAD_BREAK_FLAG_BIT)
    | ({31'h0, ddbsi_q} << EED_DBG_IMPRECISE_STORE_BREAK_FLAG_BIT);
  wire [31:0] read_mux = sel_user_hwreg_enable ? user_hwreg_enable_q : sel_cause ? cause_word : sel_epc ? epc_q
    : sel_debug ? debug_word : sel_complex_break_info ? {28'h0, cbrk_q} : sel_debug_return_pc ? debug_return_pc_q
    : sel_sram ? sram_err_q : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q <= EED_ST_RUN;
      code_q <= 5'h00;
      ce_q <= 2'h0;
      bd_q <= 1'b0;
      epc_q <= 32'h00000000;
      vector_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      vector_q <= next_vector;
      if (take_gen) begin
        code_q <= code_d;
        ce_q <= ce_d;
        bd_q <= ex_in_delay_slot_i;
        epc_q <= restart_pc;
      end else if (reg_we_i && sel_cause) begin
        ce_q <= reg_wdata_i[EED_CAUSE_CE_LSB +: 2];
      end else if (reg_we_i && sel_epc) begin
        epc_q <= reg_wdata_i;
      end
    end
  end

  // Hardware set wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      debug_return_pc_q <= 32'h00000000;
      dbd_q <= 1'b0;
      load_break_flag_q <= 1'b0;
      store_break_flag_q <= 1'b0;
      dibi_q <= 1'b0;
      ddbli_q <= 1'b0;
      ddbsi_q <= 1'b0;
      cbrk_q <= '0;
    end else if (take_dbg) begin
      debug_return_pc_q <= dbg_pc;
      dbd_q <= dbg_bd;
      load_break_flag_q <= dbrk && ex_is_load_i;
      store_break_flag_q <= dbrk && ex_is_store_i;
      dibi_q <= !dbrk && complex_instr_i;
      ddbli_q <= !dbrk && complex_load_i;
      ddbsi_q <= !dbrk && complex_store_i;
      cbrk_q <= dbrk ? '0 : complex_break_types_i;
    end else if (reg_we_i && sel_debug_return_pc) begin
      debug_return_pc_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      user_hwreg_enable_q <= 32'h00000000;
      sram_err_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
    end else begin
      if (reg_we_i && sel_user_hwreg_enable) begin
        user_hwreg_enable_q <= reg_wdata_i & EED_USER_HWREG_ENABLE_MASK;
      end
      if (sram_err_valid_i) begin
        sram_err_q <= sram_err_info_i;
      end else if (reg_we_i && sel_sram) begin
        sram_err_q <= reg_wdata_i;
      end
      rdata_q <= reg_re_i ? read_mux : 32'h00000000;
    end
  end

  // Hazard: new register values act on the next cycle
  assign user_hwreg_enable_o = user_hwreg_enable_q;
  assign kill_writeback_o = dbrk;
  assign irq_o = global_irq_enable_i && !exception_level_bit_i
    && |(irq_mask_bits_i & irq_pending_i);
  // Taken pulses come straight from the one-hot state
  assign exc_taken_o = state_q == EED_ST_GEN;
  assign debug_taken_o = state_q == EED_ST_DBG;
  assign vector_o = vector_q;
  assign reg_rdata_o = rdata_q;
endmodule // eed_core

// [tb/eed_core_props.sv]
// Checker on the eed_core ports, bound to every instance.
// Assumes one clock and the synchronous active-low reset.
module eed_core_props
  import eed_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ex_valid_i,
  input wire logic ex_arith_trap_i,
  input wire logic ex_arith_overflow_i,
  input wire logic data_break_i,
  input wire logic complex_break_i,
  input wire logic exception_level_bit_i,
  input wire logic [4:0] reg_num_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic exc_taken_o,
  input wire logic debug_taken_o,
  input wire logic [31:0] vector_o,
  input wire logic kill_writeback_o,
  input wire logic [31:0] user_hwreg_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_ov;
    ex_valid_i && ex_arith_trap_i && ex_arith_overflow_i && !exception_level_bit_i && !data_break_i
      && !complex_break_i |=> exc_taken_o && vector_o == EED_EBASE_RESET + EED_GEN_OFFSET;
  endproperty
  a_ov: assert property (p_ov) else $error("overflow missed general vector");
  property p_exl;
    ex_valid_i && exception_level_bit_i |=> !exc_taken_o;
  endproperty
  a_exl: assert property (p_exl) else $error("exception taken at exception level");
  property p_idle;
    !ex_valid_i |=> !exc_taken_o;
  endproperty
  a_idle: assert property (p_idle) else $error("exception without instruction");
  property p_dbg;
    ex_valid_i && data_break_i |=> debug_taken_o && !exc_taken_o && vector_o == EED_DEBUG_VECTOR;
  endproperty
  a_dbg: assert property (p_dbg) else $error("data break missed debug vector");
  property p_kill;
    ex_valid_i && data_break_i |-> kill_writeback_o;
  endproperty
  a_kill: assert property (p_kill) else $error("broken access completed");
  property p_cplx;
    complex_break_i |=> debug_taken_o && vector_o == EED_DEBUG_VECTOR;
  endproperty
  a_cplx: assert property (p_cplx) else $error("complex break missed debug vector");
  property p_rd;
    !reg_re_i |=> reg_rdata_o == 32'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("read data outside read cycle");
  property p_hw;
    reg_we_i && reg_num_i == EED_REG_USER_HWREG_ENABLE && reg_sel_i == EED_SEL_0
      |=> user_hwreg_enable_o == ($past(reg_wdata_i) & EED_USER_HWREG_ENABLE_MASK);
  endproperty
  a_hw: assert property (p_hw) else $error("enable register write lost");
  c_exc: cover property (exc_taken_o);
  c_dbg: cover property (debug_taken_o);
  c_cplx: cover property (complex_break_i ##1 debug_taken_o);
endmodule // eed_core_props

bind eed_core eed_core_props eed_core_props_inst (.*);

// [tb/eed_cop2_model.sv]
// Coprocessor 2 answering beside the execute stage.
// Assumes kind_i from the bench: 1 reserved, 2 error, 3 specific.
module eed_cop2_model (
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic [1:0] kind_i,
  output logic cop2_reserved_o,
  output logic cop2_error_o,
  output logic cop2_impl_o
);
  logic [2:0] junk_q = 3'h5;
  // Lines wander outside valid cycles, so stale flags never look good
  always_ff @(posedge clk_i) begin
    junk_q <= ~junk_q;
  end
  assign cop2_reserved_o = valid_i ? kind_i == 2'h1 : junk_q[0];
  assign cop2_error_o = valid_i ? kind_i == 2'h2 : junk_q[1];
  assign cop2_impl_o = valid_i ? kind_i == 2'h3 : junk_q[2];
endmodule // eed_cop2_model

// [tb/execution_exception_detect_test.sv]
// Directed bench for eed_core with its coprocessor 2 model.
// Assumes the checker is bound from its own file.
module execution_exception_detect_test;
  timeunit 1ns;
  timeprecision 1ns;
  import eed_pkg::*;
  logic clk_i, reset_n_i, ex_valid_i, ex_in_delay_slot_i, ex_compressed_mode_i, ex_undefined_i, ex_unconfigured_i;
  logic ex_cop_group_i, ex_dsp_group_i, ex_is_cop_i, ex_is_dsp_i, ex_arith_trap_i, ex_arith_overflow_i;
  logic ex_is_load_i, ex_is_store_i, data_break_i, complex_break_i, complex_instr_i, complex_load_i;
  logic complex_store_i, later_in_delay_slot_i, cop2_reserved_i, cop2_error_i, cop2_impl_i, sigproc_enable_bit_i;
  logic user_mode_i, exception_level_bit_i, global_irq_enable_i, sram_err_valid_i, reg_we_i, reg_re_i;
  logic exc_taken_o, debug_taken_o, kill_writeback_o, irq_o;
  logic [31:0] ex_pc_i, later_pc_i, sram_err_info_i, reg_wdata_i, reg_rdata_o, vector_o, user_hwreg_enable_o, v;
  logic [7:0] irq_mask_bits_i, irq_pending_i;
  logic [4:0] reg_num_i;
  logic [EED_CBRK_W-1:0] complex_break_types_i;
  logic [2:0] coproc_usable_bits_i, reg_sel_i;
  logic [1:0] ex_cop_unit_i, kind;
  int n_mismatch, check_count;
  eed_core eed_core_inst (.*);
  eed_cop2_model eed_cop2_model_inst (.clk_i, .valid_i(ex_valid_i), .kind_i(kind), .cop2_reserved_o(cop2_reserved_i),
    .cop2_error_o(cop2_error_i), .cop2_impl_o(cop2_impl_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task report_and_stop;
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (e !== s) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task acc(input logic w, input logic [4:0] n, input logic [2:0] s);
    @(posedge clk_i);
    reg_we_i <= w;
    reg_re_i <= !w;
    reg_num_i <= n;
    reg_sel_i <= s;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  // Flags: compressed, undefined, cop group, dsp group, cop, dsp, overflow, user, unit unusable, dsp off, kind
  task exc(input logic t, input logic [11:0] f, input logic [1:0] u, input logic [4:0] code, input logic [1:0] ce);
    @(posedge clk_i);
    ex_valid_i <= 1'b1;
    {ex_compressed_mode_i, ex_undefined_i, ex_cop_group_i, ex_dsp_group_i, ex_is_cop_i, ex_is_dsp_i} <= f[11:6];
    {ex_arith_trap_i, ex_arith_overflow_i} <= {2{f[5]}};
    user_mode_i <= f[4];
    coproc_usable_bits_i <= f[3] ? ~(3'h1 << u) : 3'h7;
    sigproc_enable_bit_i <= !f[2];
    kind <= f[1:0];
    ex_cop_unit_i <= u;
    ex_pc_i <= {18'h1, f, 2'h0};
    @(posedge clk_i);
    ex_valid_i <= 1'b0;
    ex_pc_i <= ~ex_pc_i;
    #1 chk("taken", {31'h0, t}, {31'h0, exc_taken_o});
    if (t) begin
      chk("vector", EED_EBASE_RESET + EED_GEN_OFFSET, vector_o);
      acc(1'b0, EED_REG_CAUSE, EED_SEL_0);
      chk("code", {27'h0, code}, {27'h0, v[6:2]});
      if (code == EED_CODE_CPU) chk("unit", {30'h0, ce}, {30'h0, v[29:28]});
      acc(1'b0, EED_REG_EPC, EED_SEL_0);
      chk("epc", {18'h1, f, 2'h0}, v);
    end
  endtask
  initial begin
    #1000000 n_mismatch++;
    report_and_stop();
  end
  initial begin
    {reset_n_i, ex_valid_i, ex_in_delay_slot_i, ex_unconfigured_i, data_break_i, complex_break_i, complex_load_i} = '0;
    {later_in_delay_slot_i, exception_level_bit_i, global_irq_enable_i, sram_err_valid_i, reg_we_i, reg_re_i} = '0;
    {ex_pc_i, later_pc_i, sram_err_info_i, reg_wdata_i, irq_mask_bits_i, irq_pending_i, reg_num_i, reg_sel_i} = '0;
    {complex_break_types_i, complex_instr_i, complex_store_i, ex_is_load_i, ex_is_store_i} = '0;
    exc_bits_init: {ex_compressed_mode_i, ex_undefined_i, ex_cop_group_i, ex_dsp_group_i, ex_is_cop_i} = '0;
    {ex_is_dsp_i, ex_arith_trap_i, ex_arith_overflow_i, user_mode_i, ex_cop_unit_i, kind} = '0;
    {coproc_usable_bits_i, sigproc_enable_bit_i} = 4'hF;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    reg_wdata_i <= 32'hFFFFFFFF;
    acc(1'b1, EED_REG_USER_HWREG_ENABLE, EED_SEL_0);
    acc(1'b0, EED_REG_USER_HWREG_ENABLE, EED_SEL_0);
    chk("user_hwreg_enable", EED_USER_HWREG_ENABLE_MASK, v);
    chk("user_enable", EED_USER_HWREG_ENABLE_MASK, user_hwreg_enable_o);
    acc(1'b0, 5'h05, EED_SEL_0);
    chk("unmapped", 32'h0, v);
    exc(1'b1, 12'h020, 2'h0, EED_CODE_OV, 2'h0);
    exc(1'b1, 12'h400, 2'h0, EED_CODE_RI, 2'h0);
    exc(1'b1, 12'h600, 2'h1, EED_CODE_CPU, 2'h1);
    exc(1'b1, 12'hE00, 2'h1, EED_CODE_RI, 2'h0);
    exc(1'b1, 12'h088, 2'h2, EED_CODE_CPU, 2'h2);
    exc(1'b1, 12'h090, 2'h0, EED_CODE_CPU, 2'h0);
    exc(1'b1, 12'h044, 2'h0, EED_CODE_SIGPROC_DISABLED_CODE, 2'h0);
    exc(1'b1, 12'h082, 2'h2, EED_CODE_C2E, 2'h0);
    exc(1'b1, 12'h083, 2'h2, EED_CODE_IS1, 2'h0);
    exc(1'b1, 12'h081, 2'h2, EED_CODE_RI, 2'h0);
    exc(1'b1, 12'h0A8, 2'h2, EED_CODE_CPU, 2'h2);
    exc(1'b1, 12'hC20, 2'h0, EED_CODE_RI, 2'h0);
    @(posedge clk_i);
    exception_level_bit_i <= 1'b1;
    exc(1'b0, 12'h020, 2'h0, EED_CODE_OV, 2'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      exception_level_bit_i <= 1'b0;
      ex_valid_i <= 1'b1;
      {ex_is_load_i, ex_is_store_i} <= i ? 2'b01 : 2'b10;
      data_break_i <= 1'b1;
      ex_in_delay_slot_i <= i[0];
      ex_pc_i <= 32'h400 + i;
      #1 chk("kill", 32'h1, {31'h0, kill_writeback_o});
      @(posedge clk_i);
      ex_valid_i <= 1'b0;
      data_break_i <= 1'b0;
      ex_in_delay_slot_i <= 1'b0;
      #1 chk("debug", 32'h1, {31'h0, debug_taken_o});
      chk("dvector", EED_DEBUG_VECTOR, vector_o);
      acc(1'b0, EED_REG_DEBUG, EED_SEL_0);
      chk("dbreak", i ? 32'h80000008 : 32'h4, v & 32'h8000000C);
      acc(1'b0, EED_REG_DEBUG_RETURN_PC, EED_SEL_0);
      chk("debug_return_pc", i ? 32'h000003FD : 32'h00000400, v);
    end
    @(posedge clk_i);
    complex_break_i <= 1'b1;
    complex_break_types_i <= 4'hA;
    {complex_instr_i, complex_store_i} <= 2'b11;
    later_pc_i <= 32'h500;
    @(posedge clk_i);
    complex_break_i <= 1'b0;
    #1 chk("cdebug", 32'h1, {31'h0, debug_taken_o});
    acc(1'b0, EED_REG_DEBUG, EED_SEL_COMPLEX_BREAK_INFO);
    chk("types", 32'hA, v & 32'hF);
    acc(1'b0, EED_REG_DEBUG, EED_SEL_0);
    chk("imprecise", 32'hA0000, v & 32'hE0000);
    acc(1'b0, EED_REG_DEBUG_RETURN_PC, EED_SEL_0);
    chk("later", 32'h500, v);
    @(posedge clk_i);
    {irq_pending_i, irq_mask_bits_i, global_irq_enable_i} <= {8'h81, 8'h80, 1'b1};
    sram_err_valid_i <= 1'b1;
    sram_err_info_i <= 32'h1234ABCD;
    @(posedge clk_i);
    sram_err_valid_i <= 1'b0;
    #1 chk("irq", 32'h1, {31'h0, irq_o});
    acc(1'b0, EED_REG_SRAMERR, EED_SEL_0);
    chk("sram", 32'h1234ABCD, v);
    report_and_stop();
  end
endmodule // execution_exception_detect_test
